// ===== bench/rae_rx_agc_energy_detect_tb_top.sv
`timescale 1ns/100ps
module rae_rx_agc_energy_detect_tb_top;
    import rae_pkg::*;
    logic       clk = 1'b0, arst_n = 1'b0, wr = 1'b0, rd = 1'b0, rx = 1'b0, hold = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, lf = 8'hce, lu = 8'hec, rdata, d, pf, pu;
    logic [2:0] cut;
    logic [3:0] rate;
    logic [4:0] gain, g0;
    logic       irq, bb_hold, svalid, same;
    int         fail_count = 0, compares = 0, irq_cnt = 0, n0, n;
    int         facs[3] = '{5, 2, 1}, bases[3] = '{0, 2, 3}, pers[3] = '{5, 32, 64};

    always #50 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

    rae_rx_agc_energy_detect #(.UNIT_CYCLES(1)) i_rae_rx_agc_energy_detect (
        .i_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_rx_state(rx), .i_bb_hold(bb_hold),
        .i_sample_valid(svalid), .i_power_filtered(pf), .i_power_unfiltered(pu),
        .o_filter_cutoff_select(cut), .o_sample_rate_select(rate), .o_rx_gain(gain),
        .o_energy_complete_interrupt(irq));

    rae_rx_chain_model i_rae_rx_chain_model (
        .i_clk(clk), .i_arst_n(arst_n), .i_rx_state(rx), .i_hold_req(hold),
        .i_level_filtered(lf), .i_level_unfiltered(lu), .o_bb_hold(bb_hold),
        .o_sample_valid(svalid), .o_power_filtered(pf), .o_power_unfiltered(pu));

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1; addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(name, rdata, exp);
    endtask : rd_chk

    task automatic wait_cyc(input int c);
        repeat (c) @(negedge clk);
    endtask : wait_cyc

    task automatic print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        chk("rst_gain", {3'h0, gain}, 8'h17);
        rd_chk("rst_front", 4'h0, 8'h01);
        rd_chk("rst_gctl", 4'h1, 8'h81);
        rd_chk("rst_gword", 4'h2, 8'h77);
        rd_chk("rst_str", 4'h3, 8'h7f);
        rd_chk("rst_mode", 4'h4, 8'h00);
        rd_chk("rst_dur", 4'h5, 8'h01);
        rd_chk("unmapped", 4'hf, 8'h00);
        // every rate code, cut-off codes wrap through the clamp
        for (int i = 0; i < 16; i++) begin
            wr_reg(4'h0, {i[2:0], 1'b0, i[3:0]});
            wait_cyc(2);
            chk("rate", {4'h0, rate}, (i inside {1, 2, 3, 4, 5, 6, 8, 10}) ? i : 1);
            chk("cutoff", {5'h0, cut}, (i[2:0] > 4) ? 4 : i[2:0]);
        end
        rx <= 1'b1;
        wr_reg(4'h1, 8'h00);
        wr_reg(4'h2, 8'h6a);
        wait_cyc(2);
        chk("man_gain", {3'h0, gain}, 8'h0a);
        rd_chk("man_word", 4'h2, 8'h6a);
        wr_reg(4'h1, 8'h08);
        wait_cyc(3);
        chk("rst_max", {3'h0, gain}, 8'h17);
        rd_chk("rst_clear", 4'h1, 8'h80);
        wr_reg(4'h1, 8'h03);
        rd_chk("frz_sw", 4'h1, 8'h87);
        g0 = gain;
        same = 1'b1;
        repeat (60) begin
            @(negedge clk);
            if (gain !== g0) same = 1'b0;
        end
        chk("frz_hold", {7'h0, same}, 8'h01);
        rd_chk("auto_word", 4'h2, 8'h77);
        wr_reg(4'h1, 8'h01);
        rd_chk("frz_off", 4'h1, 8'h81);
        hold <= 1'b1;
        wait_cyc(3);
        rd_chk("frz_bb", 4'h1, 8'h85);
        hold <= 1'b0;
        wait_cyc(3);
        rd_chk("bb_off", 4'h1, 8'h81);
        rx <= 1'b0;
        wait_cyc(4);
        rd_chk("str_off", 4'h3, 8'h7f);
        rx <= 1'b1;
        wait_cyc(40);
        rd_chk("str_filt", 4'h3, 8'hce);
        wr_reg(4'h1, 8'h41);
        wait_cyc(40);
        rd_chk("str_unf", 4'h3, 8'hec);
        lu <= 8'h14;
        wait_cyc(40);
        rd_chk("str_top", 4'h3, 8'h04);
        lu <= 8'h80;
        wait_cyc(40);
        rd_chk("str_bot", 4'h3, 8'h81);
        wr_reg(4'h1, 8'h31);
        rx <= 1'b0;
        wait_cyc(4);
        rx <= 1'b1;
        wait_cyc(100);
        rd_chk("avg64_early", 4'h3, 8'h7f);
        wait_cyc(60);
        rd_chk("avg64_done", 4'h3, 8'hce);
        wr_reg(4'h1, 8'h01);
        // one shot across three time bases
        for (int k = 0; k < 3; k++) begin
            wr_reg(4'h5, {facs[k][5:0], bases[k][1:0]});
            wr_reg(4'h4, 8'h01);
            n = 0;
            @(negedge clk);
            while (irq !== 1'b1 && n < 300) begin
                n++;
                @(negedge clk);
            end
            chk("ed_time", {7'h0, (n >= pers[k] - 1 && n <= pers[k] + 3)}, 8'h01);
            @(negedge clk);
            chk("irq_pulse", {7'h0, irq}, 8'h00);
            rd_chk("ed_res", 4'h6, 8'hce);
            rd_chk("ed_back", 4'h4, 8'h00);
        end
        wr_reg(4'h5, 8'h15);
        n0 = irq_cnt;
        wr_reg(4'h4, 8'h02);
        wait_cyc(100);
        chk("ed_rep", {7'h0, (irq_cnt - n0 inside {4, 5})}, 8'h01);
        rx <= 1'b0;
        wait_cyc(3);
        rd_chk("rep_stop", 4'h4, 8'h00);
        n0 = irq_cnt;
        wait_cyc(50);
        chk("rep_quiet", irq_cnt[7:0], n0[7:0]);
        rx <= 1'b1;
        wr_reg(4'h4, 8'h03);
        wr_reg(4'h1, 8'h03);
        wait_cyc(60);
        chk("ed_off", irq_cnt[7:0], n0[7:0]);
        rd_chk("off_res", 4'h6, 8'hce);
        wr_reg(4'h1, 8'h01);
        lf <= 8'hc4;
        wait_cyc(50);
        wr_reg(4'h4, 8'h00);
        wr_reg(4'h1, 8'h03);
        wait_cyc(40);
        chk("auto_quiet", irq_cnt[7:0], n0[7:0]);
        rd_chk("auto_res", 4'h6, 8'hc4);
        wr_reg(4'h1, 8'h01);
        print_verdict();
    end
endmodule : rae_rx_agc_energy_detect_tb_top

// ===== bench/rae_rx_chain_model.sv
`timescale 1ns/100ps
// stands in for the analog receive chain and the baseband core
module rae_rx_chain_model (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_rx_state,
    input  wire logic       i_hold_req,
    input  wire logic [7:0] i_level_filtered,
    input  wire logic [7:0] i_level_unfiltered,
    output logic            o_bb_hold,
    output logic            o_sample_valid,
    output logic      [7:0] o_power_filtered,
    output logic      [7:0] o_power_unfiltered
);
    logic [7:0] junk;

    // one sample every second cycle, only while receiving
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sample_valid <= 1'b0;
            o_bb_hold      <= 1'b0;
            junk           <= 8'h5a;
        end else begin
            o_sample_valid <= i_rx_state && !o_sample_valid;
            o_bb_hold      <= i_hold_req;
            junk           <= ~junk + 8'h13;
        end
    end

    // not receiving: lines churn so stale values are never trusted
    assign o_power_filtered   = i_rx_state ? i_level_filtered : junk;
    assign o_power_unfiltered = i_rx_state ? i_level_unfiltered : ~junk;
endmodule : rae_rx_chain_model

// ===== logic/rae_params.svh
`ifndef RAE_PARAMS_SVH
`define RAE_PARAMS_SVH
// register offsets
`define RAE_OFS_FRONTEND    4'h0
`define RAE_OFS_GAIN_CTRL   4'h1
`define RAE_OFS_GAIN_WORD   4'h2
`define RAE_OFS_STRENGTH    4'h3
`define RAE_OFS_ED_CONFIG   4'h4
`define RAE_OFS_ED_DURATION 4'h5
`define RAE_OFS_ED_RESULT   4'h6
// reset values
`define RAE_RST_FRONTEND    8'h01
`define RAE_RST_GAIN_CTRL   8'h81
`define RAE_RST_TARGET      3'h3
`define RAE_RST_ED_DURATION 8'h01
// field positions in the gain loop control register
`define RAE_GC_INPUT        6
`define RAE_GC_RESET        3
`define RAE_GC_FREEZE_STAT  2
`define RAE_GC_FREEZE       1
`define RAE_GC_ENABLE       0
// encodings and values
`define RAE_SR_DEFAULT      4'h1
`define RAE_GAIN_MAX        5'h17
`define RAE_INVALID         8'h7f
`define RAE_STRENGTH_MIN    -127
`define RAE_STRENGTH_MAX    4
`define RAE_CUTOFF_MAX      3'h4
// time base of the averaging window, in ns
`define RAE_BASE_UNIT_NS    2000
`define RAE_CLK_PERIOD_NS   100
`define RAE_UNIT_CYCLES     ((`RAE_BASE_UNIT_NS + `RAE_CLK_PERIOD_NS - 1) / `RAE_CLK_PERIOD_NS)
`endif

// ===== logic/rae_pkg.sv
package rae_pkg;
    typedef enum logic [1:0] {
        energy_mode_automatic,
        energy_mode_one_shot,
        energy_mode_repeating,
        energy_mode_disabled
    } rae_ed_mode_t;
    typedef enum logic [1:0] {
        rae_idle,
        rae_measure
    } rae_ed_state_t;
endpackage : rae_pkg

// ===== logic/rae_rx_agc_energy_detect.sv
// What this block does
// - three-bit cut-off field picks filter cut-off, codes 0 to 4, default 0
// - four-bit rate field picks sample rate, default code 1 for 4000kHz
// - unlisted rate codes act as the default 4000kHz rate
// - input select zero measures filtered signal, one measures unfiltered signal
// - averaging field picks 8, 16, 32 or 64 samples, default 8
// - writing gain reset applies maximum gain, then bit clears itself
// - freeze status reads one when baseband or software holds the loop
// - hold ends only once baseband has released and software has cleared freeze control
// - freeze control one freezes gain, zero lets the loop adapt
// - enable one adjusts gain automatically, zero follows the written word
// - target level field picks -21dB to -42dB, default code 3
// - with automatic gain on, reading the word returns gain in use
// - with automatic gain off, writing the word while receiving sets gain directly
// - word value 23 is maximum gain, each step is 3dB
// - signal strength reports power in dBm, 127 marks invalid
// - valid strength values are signed, range -127 to +4
// - automatic mode starts a measurement whenever the loop is held
// - mode 1 one measurement, 2 repeating, 3 disabled
// - averaging time is duration factor times the selected time base
// - time base codes give 2, 8, 32, 128 us, default 8 us
// - result register holds averaged energy, signed, -127 to +4
// - measurements run only in receive; leaving it returns mode to automatic
// - each completed single or repeating period stores result and raises complete
// - single mode returns the mode field to automatic after completing
// - cancelled automatic measurement may leave an incorrect or invalid result
`timescale 1ns/100ps
`include "rae_params.svh"
module rae_rx_agc_energy_detect
    import rae_pkg::*;
#(
    parameter int UNIT_CYCLES = `RAE_UNIT_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_arst_n,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_rx_state,
    input  wire logic       i_bb_hold,
    input  wire logic       i_sample_valid,
    input  wire logic [7:0] i_power_filtered,
    input  wire logic [7:0] i_power_unfiltered,
    output logic      [2:0] o_filter_cutoff_select,
    output logic      [3:0] o_sample_rate_select,
    output logic      [4:0] o_rx_gain,
    output logic            o_energy_complete_interrupt
);
    logic [7:0]   rx_frontend_config;
    logic         gain_input_select;
    logic [1:0]   gain_average_count;
    logic         gain_reset;
    logic         freeze_control;
    logic         gain_enable;
    logic [2:0]   gain_target_level;
    logic [4:0]   gain_control_word;
    logic [7:0]   signal_strength;
    rae_ed_mode_t energy_mode_field;
    logic [7:0]   energy_detect_duration;
    logic [7:0]   energy_result;
    logic         freeze_status;
    logic         wr_frontend, wr_gctrl, wr_gword, wr_edc, wr_edd;
    logic [7:0]   sel_power;
    logic [6:0]   avg_cnt;
    logic [6:0]   avg_len;
    logic [13:0]  avg_sum;
    logic [7:0]   avg_level;
    rae_ed_state_t ed_state;
    logic [13:0]  tick_cnt;
    logic [7:0]   unit_cnt;
    logic [7:0]   units_left;
    logic [24:0]  ed_sum;
    logic [16:0]  ed_num;
    logic         ed_start;
    logic         ed_period_end;
    logic         ed_finish;
    logic [13:0]  unit_len;
    logic [7:0]   next_result;

    assign wr_frontend = i_wr && i_addr == `RAE_OFS_FRONTEND;
    assign wr_gctrl    = i_wr && i_addr == `RAE_OFS_GAIN_CTRL;
    assign wr_gword    = i_wr && i_addr == `RAE_OFS_GAIN_WORD;
    assign wr_edc      = i_wr && i_addr == `RAE_OFS_ED_CONFIG;
    assign wr_edd      = i_wr && i_addr == `RAE_OFS_ED_DURATION;

    // front end: cut-off codes above 4 are clamped, unlisted rates fall back
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_frontend_config <= `RAE_RST_FRONTEND;
        end else if (wr_frontend) begin
            rx_frontend_config <= {i_wdata[7:5], 1'b0, i_wdata[3:0]};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_filter_cutoff_select <= 3'h0;
            o_sample_rate_select   <= `RAE_SR_DEFAULT;
        end else begin
            o_filter_cutoff_select <= (rx_frontend_config[7:5] > `RAE_CUTOFF_MAX) ?
                                      `RAE_CUTOFF_MAX : rx_frontend_config[7:5];
            unique case (rx_frontend_config[3:0])
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha: begin
                    o_sample_rate_select <= rx_frontend_config[3:0];
                end
                default: begin
                    o_sample_rate_select <= `RAE_SR_DEFAULT;
                end
            endcase
        end
    end

    // gain loop control register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            gain_input_select  <= 1'b0;
            gain_average_count <= 2'h0;
            gain_reset         <= 1'b0;
            freeze_control     <= 1'b0;
            gain_enable        <= 1'b1;
            gain_target_level  <= `RAE_RST_TARGET;
        end else begin
            if (wr_gctrl) begin
                gain_input_select  <= i_wdata[`RAE_GC_INPUT];
                gain_average_count <= i_wdata[5:4];
                freeze_control     <= i_wdata[`RAE_GC_FREEZE];
                gain_enable        <= i_wdata[`RAE_GC_ENABLE];
            end
            // command runs in one cycle, so the bit drops right after
            gain_reset <= wr_gctrl && i_wdata[`RAE_GC_RESET];
            if (wr_gword) begin
                gain_target_level <= i_wdata[7:5];
            end
        end
    end

    assign freeze_status = freeze_control || i_bb_hold;
    assign sel_power = gain_input_select ? i_power_unfiltered : i_power_filtered;
    assign avg_len = 7'd8 << gain_average_count;

    // sample averager feeds strength; a simple one-step loop tracks the target
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            avg_cnt         <= 7'h00;
            avg_sum         <= 14'h0000;
            avg_level       <= `RAE_INVALID;
            gain_control_word <= `RAE_GAIN_MAX;
        end else if (gain_reset || !i_rx_state) begin
            avg_cnt   <= 7'h00;
            avg_sum   <= 14'h0000;
            avg_level <= `RAE_INVALID;
            if (gain_reset) begin
                gain_control_word <= `RAE_GAIN_MAX;
            end
        end else begin
            if (!gain_enable && wr_gword) begin
                gain_control_word <= i_wdata[4:0];
            end
            if (i_sample_valid) begin
                if (avg_cnt == avg_len - 7'd1) begin
                    avg_cnt   <= 7'h00;
                    avg_sum   <= 14'h0000;
                    avg_level <= 8'((avg_sum + {{6{sel_power[7]}}, sel_power}) >>>
                                 (3 + gain_average_count));
                    // target compared as dB below full scale: 3dB per step
                    if (gain_enable && !freeze_status) begin
                        if ($signed(avg_level) > -$signed({3'h0, gain_target_level}) * 3
                                - 21 && gain_control_word != 5'h00) begin
                            gain_control_word <= gain_control_word - 5'h01;
                        end else if (gain_control_word < `RAE_GAIN_MAX) begin
                            gain_control_word <= gain_control_word + 5'h01;
                        end
                    end
                end else begin
                    avg_cnt <= avg_cnt + 7'h01;
                    avg_sum <= avg_sum + {{6{sel_power[7]}}, sel_power};
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            signal_strength <= `RAE_INVALID;
            o_rx_gain       <= `RAE_GAIN_MAX;
        end else begin
            o_rx_gain <= gain_control_word;
            if (!i_rx_state || avg_level == `RAE_INVALID) begin
                signal_strength <= `RAE_INVALID;
            end else if ($signed(avg_level) > `RAE_STRENGTH_MAX) begin
                signal_strength <= 8'(`RAE_STRENGTH_MAX);
            end else if ($signed(avg_level) < `RAE_STRENGTH_MIN) begin
                signal_strength <= 8'(`RAE_STRENGTH_MIN);
            end else begin
                signal_strength <= avg_level;
            end
        end
    end

    // energy detection
    assign unit_len = 14'(UNIT_CYCLES) << (2 * energy_detect_duration[1:0]);
    assign ed_period_end = ed_state == rae_measure && tick_cnt == unit_len - 14'h1 &&
                           units_left <= 8'h01;
    assign ed_start = i_rx_state && ed_state == rae_idle && !wr_edc &&
                      (energy_mode_field == energy_mode_one_shot ||
                       energy_mode_field == energy_mode_repeating ||
                       (energy_mode_field == energy_mode_automatic && freeze_status));
    assign ed_finish = ed_period_end && energy_detect_duration[7:2] != 6'h00;
    // rounded mean, half away from zero: plain truncation would pull negatives up
    assign next_result = (ed_num == 17'h0) ? `RAE_INVALID :
                         8'((ed_sum[24] ? $signed(ed_sum) - $signed({1'b0, ed_num[16:1]})
                                        : $signed(ed_sum) + $signed({1'b0, ed_num[16:1]})) /
                            $signed({1'b0, ed_num}));

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            energy_detect_duration <= `RAE_RST_ED_DURATION;
        end else if (wr_edd) begin
            energy_detect_duration <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            energy_mode_field <= energy_mode_automatic;
        end else if (!i_rx_state) begin
            energy_mode_field <= energy_mode_automatic;
        end else if (wr_edc) begin
            energy_mode_field <= rae_ed_mode_t'(i_wdata[1:0]);
        end else if (ed_finish && energy_mode_field == energy_mode_one_shot) begin
            energy_mode_field <= energy_mode_automatic;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ed_state   <= rae_idle;
            tick_cnt   <= 14'h0000;
            units_left <= 8'h00;
            ed_sum     <= 25'h0000000;
            ed_num     <= 17'h00000;
        end else if (!i_rx_state || wr_edc ||
                     (ed_state == rae_measure && energy_mode_field == energy_mode_automatic
                      && !freeze_status)) begin
            ed_state <= rae_idle;
        end else if (ed_start || (ed_finish && energy_mode_field == energy_mode_repeating)) begin
            ed_state   <= rae_measure;
            tick_cnt   <= 14'h0000;
            units_left <= {2'h0, energy_detect_duration[7:2]};
            ed_sum     <= 25'h0000000;
            ed_num     <= 17'h00000;
        end else if (ed_finish || ed_period_end) begin
            ed_state <= rae_idle;
        end else if (ed_state == rae_measure) begin
            if (tick_cnt == unit_len - 14'h1) begin
                tick_cnt   <= 14'h0000;
                units_left <= units_left - 8'h01;
            end else begin
                tick_cnt <= tick_cnt + 14'h0001;
            end
            if (signal_strength != `RAE_INVALID) begin
                ed_sum <= ed_sum + {{17{signal_strength[7]}}, signal_strength};
                ed_num <= ed_num + 17'h00001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            energy_result               <= `RAE_INVALID;
            o_energy_complete_interrupt <= 1'b0;
        end else begin
            o_energy_complete_interrupt <= ed_finish &&
                                           energy_mode_field != energy_mode_automatic;
            if (ed_finish) begin
                energy_result <= next_result;
            end
        end
    end

    // register read, data one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `RAE_OFS_FRONTEND:    o_rdata <= rx_frontend_config;
                `RAE_OFS_GAIN_CTRL:   o_rdata <= {1'b1, gain_input_select, gain_average_count,
                                                  gain_reset, freeze_status, freeze_control,
                                                  gain_enable};
                `RAE_OFS_GAIN_WORD:   o_rdata <= {gain_target_level, gain_control_word};
                `RAE_OFS_STRENGTH:    o_rdata <= signal_strength;
                `RAE_OFS_ED_CONFIG:   o_rdata <= {6'h00, energy_mode_field};
                `RAE_OFS_ED_DURATION: o_rdata <= energy_detect_duration;
                `RAE_OFS_ED_RESULT:   o_rdata <= energy_result;
                default:              o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    gain_reset_pulse_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (gain_reset && !(wr_gctrl && i_wdata[`RAE_GC_RESET]))
        |=> !gain_reset && gain_control_word == `RAE_GAIN_MAX)
        else $error("gain reset did not restore maximum gain");
    freeze_status_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (i_rd && i_addr == `RAE_OFS_GAIN_CTRL && (i_bb_hold || freeze_control))
        |=> o_rdata[`RAE_GC_FREEZE_STAT])
        else $error("freeze status low while held");
    rate_fallback_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        rx_frontend_config[3:0] == 4'h7 |=> o_sample_rate_select == `RAE_SR_DEFAULT)
        else $error("unlisted rate code not mapped to default");
    manual_gain_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (!gain_enable && wr_gword && !gain_reset && i_rx_state)
        |=> ##1 o_rx_gain == $past(i_wdata[4:0], 2))
        else $error("manual gain not applied");
    single_done_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (ed_finish && energy_mode_field == energy_mode_one_shot && i_rx_state && !wr_edc)
        |=> energy_mode_field == energy_mode_automatic && o_energy_complete_interrupt)
        else $error("single mode did not return to automatic");
    leave_rx_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        !i_rx_state |=> energy_mode_field == energy_mode_automatic && ed_state == rae_idle)
        else $error("leaving receive did not stop detection");
    strength_range_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        signal_strength == `RAE_INVALID || ($signed(signal_strength) <= 4 &&
        $signed(signal_strength) >= -127))
        else $error("strength out of range");
    auto_no_irq_a: assert property (@(posedge i_clk) disable iff (!i_arst_n)
        (ed_finish && energy_mode_field == energy_mode_automatic)
        |=> !o_energy_complete_interrupt)
        else $error("automatic completion raised interrupt");
    single_cov: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        energy_mode_field == energy_mode_one_shot ##[1:1000] o_energy_complete_interrupt);
    cont_cov: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        o_energy_complete_interrupt && energy_mode_field == energy_mode_repeating);
    freeze_cov: cover property (@(posedge i_clk) disable iff (!i_arst_n)
        i_bb_hold && ed_state == rae_measure);
endmodule : rae_rx_agc_energy_detect
